// ==== src/ddpu_consts.vh ====
// constants for the dual data pointer unit
`ifndef DDPU_CONSTS_VH
`define DDPU_CONSTS_VH
`define DDPU_ADDR_CTRL 8'ha7
`define DDPU_ADDR_LOW 8'h82
`define DDPU_ADDR_HIGH 8'h83
`define DDPU_ADDR_PAGE 8'h84
`define DDPU_CTRL_RESET 8'h00
`define DDPU_PTR_RESET 24'h000000
`define DDPU_BIT_SEL 0
`define DDPU_BIT_SWAP 6
`define DDPU_MAIN_MODE 3:2
`define DDPU_SHADOW_MODE 5:4
`define DDPU_CTRL_WMASK 8'h7d
`define DDPU_MODE_NONE 2'h0
`define DDPU_MODE_INC 2'h1
`define DDPU_MODE_DEC 2'h2
`define DDPU_MODE_TOGGLE 2'h3
`define DDPU_PTR_ONE 24'h000001
`define DDPU_BYTE_W 8
`define DDPU_NUM_BYTES 3
`define DDPU_LOW_FIELD 7:0
`define DDPU_HIGH_FIELD 15:8
`define DDPU_PAGE_FIELD 23:16
`endif

// ==== src/ddpu_dual_pointer.v ====
// dual 24-bit data pointer with select, post-adjust and auto-swap
// How it works
// - two pointers, select bit zero picks one
// - main pointer visible through three byte registers
// - shadow pointer in same bytes, main untouched
// - auto-swap bit six inverts select after move
// - bits five-four set shadow pointer adjustment
// - bits three-two set main pointer adjustment
// - toggle mode inverts only pointer bit zero
// - control bit one unimplemented, reads zero
// - only pointer-addressed moves adjust or swap
// - all pointer users see the selected pointer
`include "ddpu_consts.vh"
module ddpu_dual_pointer (
  input wire clock,
  input wire rst_n,
  input wire [7:0] reg_addr,
  input wire reg_write,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output wire reg_hit,
  input wire pointer_move_done,
  output reg [23:0] active_pointer,
  output reg [7:0] pointer_control
);

  // decoded accesses and control fields
  wire ctrl_hit;
  wire [`DDPU_NUM_BYTES-1:0] byte_hit;
  wire ctrl_write;
  wire ptr_write;
  wire move_taken;
  wire sel;
  wire swap_en;
  wire [1:0] main_mode;
  wire [1:0] shadow_mode;
  wire [7:0] ctrl_wr_val;

  // byte-merged write values and adjusted candidates
  wire [23:0] main_wr_val;
  wire [23:0] shadow_wr_val;
  wire [23:0] main_inc;
  wire [23:0] main_dec;
  wire [23:0] main_tgl;
  wire [23:0] shadow_inc;
  wire [23:0] shadow_dec;
  wire [23:0] shadow_tgl;
  reg [23:0] main_adj;
  reg [23:0] shadow_adj;

  // pointer storage
  reg [23:0] main_ptr;
  reg [23:0] shadow_ptr;
  reg [23:0] next_main_ptr;
  reg [23:0] next_shadow_ptr;
  reg [7:0] next_ctrl;
  genvar gi;

  assign sel = pointer_control[`DDPU_BIT_SEL];
  assign swap_en = pointer_control[`DDPU_BIT_SWAP];
  assign main_mode = pointer_control[`DDPU_MAIN_MODE];
  assign shadow_mode = pointer_control[`DDPU_SHADOW_MODE];

  assign ctrl_hit = (reg_addr == `DDPU_ADDR_CTRL);
  assign reg_hit = ctrl_hit | (|byte_hit);
  assign ctrl_write = reg_write & ctrl_hit;
  assign ptr_write = reg_write & (|byte_hit);
  // a write in the same cycle as a move wins; the move is dropped
  assign move_taken = pointer_move_done & ~reg_write;
  assign ctrl_wr_val = reg_wdata & `DDPU_CTRL_WMASK;

  // one lane per byte register: decode and merge of the written byte
  generate
    for (gi = 0; gi < `DDPU_NUM_BYTES; gi = gi + 1) begin : g_byte
      localparam [7:0] BYTE_ADDR = `DDPU_ADDR_LOW + gi;
      assign byte_hit[gi] = (reg_addr == BYTE_ADDR);
      assign main_wr_val[gi*`DDPU_BYTE_W +: `DDPU_BYTE_W] = byte_hit[gi] ? reg_wdata : main_ptr[gi*`DDPU_BYTE_W +: `DDPU_BYTE_W];
      assign shadow_wr_val[gi*`DDPU_BYTE_W +: `DDPU_BYTE_W] = byte_hit[gi] ? reg_wdata : shadow_ptr[gi*`DDPU_BYTE_W +: `DDPU_BYTE_W];
    end
  endgenerate

  // candidate post-adjusted values, wrapping over 24 bits
  assign main_inc = main_ptr + `DDPU_PTR_ONE;
  assign main_dec = main_ptr - `DDPU_PTR_ONE;
  assign main_tgl = main_ptr ^ `DDPU_PTR_ONE;
  assign shadow_inc = shadow_ptr + `DDPU_PTR_ONE;
  assign shadow_dec = shadow_ptr - `DDPU_PTR_ONE;
  assign shadow_tgl = shadow_ptr ^ `DDPU_PTR_ONE;

  // main pointer adjustment by its own mode field
  always @* begin
    case (main_mode)
      `DDPU_MODE_INC: begin
        main_adj = main_inc;
      end
      `DDPU_MODE_DEC: begin
        main_adj = main_dec;
      end
      `DDPU_MODE_TOGGLE: begin
        main_adj = main_tgl;
      end
      default: begin
        main_adj = main_ptr;
      end
    endcase
  end

  // shadow pointer adjustment by its own mode field
  always @* begin
    case (shadow_mode)
      `DDPU_MODE_INC: begin
        shadow_adj = shadow_inc;
      end
      `DDPU_MODE_DEC: begin
        shadow_adj = shadow_dec;
      end
      `DDPU_MODE_TOGGLE: begin
        shadow_adj = shadow_tgl;
      end
      default: begin
        shadow_adj = shadow_ptr;
      end
    endcase
  end

  // main pointer: byte writes first, then post-adjust
  always @* begin
    next_main_ptr = main_ptr;
    if (ptr_write && !sel) begin
      next_main_ptr = main_wr_val;
    end else if (move_taken && !sel) begin
      next_main_ptr = main_adj;
    end
  end

  // shadow pointer: main copy is never touched from here
  always @* begin
    next_shadow_ptr = shadow_ptr;
    if (ptr_write && sel) begin
      next_shadow_ptr = shadow_wr_val;
    end else if (move_taken && sel) begin
      next_shadow_ptr = shadow_adj;
    end
  end

  // swap happens on the same edge as the adjust of the used pointer
  always @* begin
    next_ctrl = pointer_control;
    if (ctrl_write) begin
      next_ctrl = ctrl_wr_val;
    end else if (move_taken && swap_en) begin
      next_ctrl[`DDPU_BIT_SEL] = ~sel;
    end
  end

  // async reset clears both pointers and the control register
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      main_ptr <= `DDPU_PTR_RESET;
    end else begin
      main_ptr <= next_main_ptr;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shadow_ptr <= `DDPU_PTR_RESET;
    end else begin
      shadow_ptr <= next_shadow_ptr;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pointer_control <= `DDPU_CTRL_RESET;
    end else begin
      pointer_control <= next_ctrl;
    end
  end

  // every pointer user sees the selected copy
  always @* begin
    active_pointer = sel ? shadow_ptr : main_ptr;
  end

  // byte views of the selected pointer
  wire [7:0] active_low;
  wire [7:0] active_high;
  wire [7:0] active_page;
  assign active_low = active_pointer[`DDPU_LOW_FIELD];
  assign active_high = active_pointer[`DDPU_HIGH_FIELD];
  assign active_page = active_pointer[`DDPU_PAGE_FIELD];

  // unimplemented bits are masked again on the read path
  wire [7:0] ctrl_rd_val;
  assign ctrl_rd_val = pointer_control & `DDPU_CTRL_WMASK;

  // read mux; unmapped addresses read zero
  always @* begin
    case (reg_addr)
      `DDPU_ADDR_CTRL: begin
        reg_rdata = ctrl_rd_val;
      end
      `DDPU_ADDR_LOW: begin
        reg_rdata = active_low;
      end
      `DDPU_ADDR_HIGH: begin
        reg_rdata = active_high;
      end
      `DDPU_ADDR_PAGE: begin
        reg_rdata = active_page;
      end
      default: begin
        reg_rdata = 8'h00;
      end
    endcase
  end
endmodule

// ==== testbench/ddpu_core_model.sv ====
// core model: one move pulse per request
module ddpu_core_model(input wire clock,input wire req,output reg pointer_move_done=1'b0);
timeunit 1ns; timeprecision 1ns;
always @(posedge clock) pointer_move_done<=req;
endmodule

// ==== testbench/ddpu_dual_pointer_test.sv ====
// self-checking bench for the pointer unit
module ddpu_dual_pointer_test;
timeunit 1ns; timeprecision 1ns;
reg clock=0,rst_n=0,reg_write=0,req=0;
reg [7:0] reg_addr=8'h00,reg_wdata=8'h00;
wire [7:0] reg_rdata,pointer_control;
wire [23:0] active_pointer;
wire reg_hit,pointer_move_done;
integer miscompares=0,checks_done=0,cyc=0;
ddpu_dual_pointer uut(.*);
ddpu_core_model core(.*);
initial forever #2 clock=~clock;
always @(posedge clock) begin
  cyc<=cyc+1;
  if (cyc==400) begin miscompares=miscompares+1; report_and_stop; end
end
task w(input [7:0] a,d); @(posedge clock) begin reg_addr<=a; reg_wdata<=d; reg_write<=1; end
  @(posedge clock) reg_write<=0; endtask
task m; @(posedge clock) req<=1; @(posedge clock) req<=0; @(posedge clock); endtask
task c(input [7:0] a,e); @(posedge clock) reg_addr<=a; #1 checks_done=checks_done+1;
  if (reg_rdata!==e) begin miscompares=miscompares+1; $display("[ERR] %0t rdata",$time); end endtask
task p(input [23:0] e); @(posedge clock) #1 checks_done=checks_done+1;
  if (active_pointer!==e) begin miscompares=miscompares+1; $display("[ERR] %0t pointer",$time); end endtask
task h(input [7:0] a,input e); @(posedge clock) reg_addr<=a; #1 checks_done=checks_done+1;
  if (reg_hit!==e) begin miscompares=miscompares+1; $display("[ERR] %0t hit",$time); end endtask
task report_and_stop; $display("%0d/%0d",miscompares,checks_done);
  if (miscompares==0&&checks_done>0) $display("SIMULATION PASSED");
  else $display("SIMULATION FAILED");
  $finish; endtask
initial begin
  repeat (12) @(posedge clock);
  rst_n<=1;
  c(8'ha7,8'h00);
  w(8'ha7,8'hfe); c(8'ha7,8'h7c);
  w(8'h82,8'h12); w(8'h84,8'h56); w(8'ha7,8'h01);
  w(8'h82,8'hff); w(8'h83,8'hff); w(8'h84,8'hff);
  w(8'ha7,8'h55); m; c(8'ha7,8'h54);
  c(8'h84,8'h56);
  p(24'h560012);
  w(8'ha7,8'h04); m; c(8'h82,8'h13);
  w(8'ha7,8'h3c); m; c(8'h82,8'h12);
  w(8'ha7,8'h28); m; c(8'h82,8'h11);
  w(8'ha7,8'h01); c(8'h83,8'h00);
  h(8'h85,1'b0);
  h(8'h83,1'b1);
  report_and_stop;
end
endmodule

// ==== testbench/ddpu_sva.sv ====
// port assertions for the pointer unit
module ddpu_sva(input wire clock,input wire rst_n,input wire reg_write,
input wire pointer_move_done,input wire [23:0] active_pointer,input wire [7:0] pointer_control);
timeunit 1ns; timeprecision 1ns;
default clocking @(posedge clock); endclocking
default disable iff (!rst_n);
wire v=pointer_move_done&~reg_write;
wire [7:0] p=pointer_control;
wire [23:0] q=active_pointer;
property p_rsv; !p[7]&&!p[1]; endproperty
a_rsv: assert property(p_rsv) else $error("rsv");
property p_swp; v&&p[6] |=> p[0]!=$past(p[0]); endproperty
a_swp: assert property(p_swp) else $error("swp");
property p_hld; !v&&!reg_write |=> $stable(q); endproperty
a_hld: assert property(p_hld) else $error("hld");
property p_inc; v&&p[6:0]==7'h04 |=> q-$past(q)==24'h000001; endproperty
a_inc: assert property(p_inc) else $error("inc");
property p_tgl; v&&p[6:0]==7'h3c |=> (q^$past(q))==24'h000001; endproperty
a_tgl: assert property(p_tgl) else $error("tgl");
property p_dec; v&&p[6:0]==7'h28 |=> $past(q)-q==24'h000001; endproperty
a_dec: assert property(p_dec) else $error("dec");
cover property(v&&p[6]);
cover property(v&&p[3:2]==2'h3);
cover property(reg_write);
endmodule
bind ddpu_dual_pointer ddpu_sva chk(.*);
